//--- sgp_defs.vh
/*
  Constants for the six-pin general purpose I/O port: register offsets,
  field positions, reset values and timing counts.
  Assumes inclusion by bare name from the port's design files.
*/
`ifndef SGP_DEFS_VH
`define SGP_DEFS_VH

`define SGP_ADDR_W 12
`define SGP_PINS 6

`define SGP_OFF_CONFIG 12'h1E0
`define SGP_OFF_DATA_DIR 12'h1E4
`define SGP_OFF_IRQ_STS_EN 12'h1E8
`define SGP_OFF_TOP_STATUS 12'h058
`define SGP_OFF_TOP_ENABLE 12'h05C

`define SGP_LOW_LSB 0
`define SGP_HIGH_LSB 16
`define SGP_TOP_EVENT_BIT 12

`define SGP_CONFIG_RST 32'h00000000
`define SGP_DATA_DIR_RST 32'h00000000
`define SGP_IRQ_STS_EN_RST 32'h00000000

`define SGP_CLK_PERIOD_NS 10
`define SGP_MIN_TRIGGER_NS 40
`define SGP_MIN_TRIGGER_CYC (`SGP_MIN_TRIGGER_NS / `SGP_CLK_PERIOD_NS)
`define SGP_SETTLE_CYC 3'h4

`endif

//--- sgp_pin_sync.v
/*
  Three-stage input synchroniser for the six pins; a new level is
  accepted once the second and third stages agree.
  Assumes pins are asynchronous to clock_in.
*/
`timescale 1ns/10ps
`include "sgp_defs.vh"
module sgp_pin_sync (
  input wire clock_in,
  input wire reset_in,
  input wire [5:0] pin_in,
  output wire [5:0] level_out
);
  genvar i;
  generate
    for (i = 0; i < `SGP_PINS; i = i + 1) begin : g_pin
      reg s1_r;
      reg s2_r;
      reg s3_r;
      reg lvl_r;
      always @(posedge clock_in) begin
        if (reset_in) begin
          s1_r <= 1'b0;
          s2_r <= 1'b0;
          s3_r <= 1'b0;
          lvl_r <= 1'b0;
        end else begin
          s1_r <= pin_in[i];
          s2_r <= s1_r;
          s3_r <= s2_r;
          if (s2_r == s3_r) begin
            lvl_r <= s3_r;
          end
        end
      end
      assign level_out[i] = lvl_r;
    end
  endgenerate
endmodule

//--- sgp_pin_drive.v
/*
  Output driver for the six pins: direction, open-drain or push-pull,
  and hand-over to the indicator function.
  Assumes indicator values arrive from the indicator logic outside.
*/
`timescale 1ns/10ps
`include "sgp_defs.vh"
module sgp_pin_drive (
  input wire clock_in,
  input wire reset_in,
  input wire [5:0] pin_direction_in,
  input wire [5:0] pin_driver_type_in,
  input wire [5:0] pin_data_value_in,
  input wire [5:0] indicator_enable_in,
  input wire [5:0] indicator_value_in,
  input wire [5:0] indicator_oe_in,
  output wire [5:0] pin_out,
  output wire [5:0] pin_oe_out
);
  reg [5:0] pin_r;
  reg [5:0] oe_r;
  genvar i;
  generate
    for (i = 0; i < `SGP_PINS; i = i + 1) begin : g_drv
      always @(posedge clock_in) begin
        if (reset_in) begin
          pin_r[i] <= 1'b0;
          oe_r[i] <= 1'b0;
        end else if (indicator_enable_in[i]) begin
          pin_r[i] <= indicator_value_in[i];
          oe_r[i] <= indicator_oe_in[i];
        end else if (!pin_direction_in[i]) begin
          pin_r[i] <= 1'b0;
          oe_r[i] <= 1'b0;
        end else if (pin_driver_type_in[i]) begin
          pin_r[i] <= pin_data_value_in[i];
          oe_r[i] <= 1'b1;
        end else begin
          pin_r[i] <= 1'b0;
          oe_r[i] <= ~pin_data_value_in[i];
        end
      end
    end
  endgenerate
  assign pin_out = pin_r;
  assign pin_oe_out = oe_r;
endmodule

//--- sgp_port.v
/*
  Six-pin general purpose I/O port with its three registers, level
  interrupt flags and the GPIO event bit of the top interrupt status.
  Assumes a plain register port with read data one cycle after the
  strobe, and a board that resolves each pin from its output enable.
*/
// The strobed register port was decided locally.
`timescale 1ns/10ps
`include "sgp_defs.vh"
module sgp_port (
  input wire clock_in,
  input wire reset_in,
  input wire [11:0] reg_addr_in,
  input wire [31:0] reg_wdata_in,
  input wire reg_write_in,
  input wire reg_read_in,
  output wire [31:0] reg_rdata_out,
  input wire [5:0] pin_in,
  output wire [5:0] pin_out,
  output wire [5:0] pin_oe_out,
  input wire [5:0] indicator_enable_in,
  input wire [5:0] indicator_value_in,
  input wire [5:0] indicator_oe_in,
  output wire gpio_event_out,
  output wire irq_out
);
  reg [5:0] level_trigger_polarity_r;
  reg [5:0] pin_driver_type_r;
  reg [5:0] pin_direction_r;
  reg [5:0] pin_data_value_r;
  reg [5:0] irq_enable_r;
  reg [5:0] irq_flag_r;
  reg [5:0] irq_flag_nxt;
  reg top_event_enable_r;
  reg [31:0] rdata_r;
  reg [31:0] rdata_nxt;
  wire [5:0] pin_level;
  wire [5:0] trigger;
  wire [5:0] clear_mask;
  wire wr_config;
  wire wr_data_dir;
  wire wr_sts_en;
  wire wr_top_en;
  wire [5:0] data_view;
  wire event_any;
  reg [2:0] settle_r;
  wire settled;

  // Synchronised levels give about 40 ns of latency; glitches shorter than 20 ns may be missed
  sgp_pin_sync u_sync (
    .clock_in(clock_in),
    .reset_in(reset_in),
    .pin_in(pin_in),
    .level_out(pin_level)
  );

  sgp_pin_drive u_drive (
    .clock_in(clock_in),
    .reset_in(reset_in),
    .pin_direction_in(pin_direction_r),
    .pin_driver_type_in(pin_driver_type_r),
    .pin_data_value_in(pin_data_value_r),
    .indicator_enable_in(indicator_enable_in),
    .indicator_value_in(indicator_value_in),
    .indicator_oe_in(indicator_oe_in),
    .pin_out(pin_out),
    .pin_oe_out(pin_oe_out)
  );

  assign wr_config = reg_write_in && (reg_addr_in == `SGP_OFF_CONFIG);
  assign wr_data_dir = reg_write_in && (reg_addr_in == `SGP_OFF_DATA_DIR);
  assign wr_sts_en = reg_write_in && (reg_addr_in == `SGP_OFF_IRQ_STS_EN);
  assign wr_top_en = reg_write_in && (reg_addr_in == `SGP_OFF_TOP_ENABLE);

  // Synchroniser resets to zero, which would look like a low trigger on every
  // idle-high pin; flags stay quiet until its stages hold real pin levels
  always @(posedge clock_in) begin
    if (reset_in) begin
      settle_r <= 3'h0;
    end else if (settle_r != `SGP_SETTLE_CYC) begin
      settle_r <= settle_r + 3'h1;
    end
  end
  assign settled = (settle_r == `SGP_SETTLE_CYC);

  // Indicator pins never raise general I/O interrupts
  assign trigger = ~(pin_level ^ level_trigger_polarity_r) & ~indicator_enable_in
    & {6{settled}};
  assign clear_mask = wr_sts_en ? reg_wdata_in[5:0] : 6'h00;

  always @* begin
    // Set wins over clear, so a held level re-arms at once
    irq_flag_nxt = (irq_flag_r & ~clear_mask) | trigger;
  end

  always @(posedge clock_in) begin
    if (reset_in) begin
      level_trigger_polarity_r <= 6'h00;
      pin_driver_type_r <= 6'h00;
      pin_direction_r <= 6'h00;
      pin_data_value_r <= 6'h00;
      irq_enable_r <= 6'h00;
      irq_flag_r <= 6'h00;
      top_event_enable_r <= 1'b0;
    end else begin
      irq_flag_r <= irq_flag_nxt;
      if (wr_config) begin
        level_trigger_polarity_r <= reg_wdata_in[21:16];
        pin_driver_type_r <= reg_wdata_in[5:0];
      end
      if (wr_data_dir) begin
        pin_direction_r <= reg_wdata_in[21:16];
        pin_data_value_r <= reg_wdata_in[5:0];
      end
      if (wr_sts_en) begin
        irq_enable_r <= reg_wdata_in[21:16];
      end
      if (wr_top_en) begin
        top_event_enable_r <= reg_wdata_in[`SGP_TOP_EVENT_BIT];
      end
    end
  end

  assign data_view = (pin_direction_r & pin_data_value_r) | (~pin_direction_r & pin_level);
  assign event_any = |(irq_flag_r & irq_enable_r);

  always @* begin
    rdata_nxt = 32'h00000000;
    case (reg_addr_in)
      `SGP_OFF_CONFIG: begin
        rdata_nxt[21:16] = level_trigger_polarity_r;
        rdata_nxt[5:0] = pin_driver_type_r;
      end
      `SGP_OFF_DATA_DIR: begin
        rdata_nxt[21:16] = pin_direction_r;
        rdata_nxt[5:0] = data_view;
      end
      `SGP_OFF_IRQ_STS_EN: begin
        rdata_nxt[21:16] = irq_enable_r;
        rdata_nxt[5:0] = irq_flag_r;
      end
      `SGP_OFF_TOP_STATUS: begin
        rdata_nxt[`SGP_TOP_EVENT_BIT] = event_any;
      end
      `SGP_OFF_TOP_ENABLE: begin
        rdata_nxt[`SGP_TOP_EVENT_BIT] = top_event_enable_r;
      end
      default: begin
        rdata_nxt = 32'h00000000;
      end
    endcase
  end

  always @(posedge clock_in) begin
    if (reset_in) begin
      rdata_r <= 32'h00000000;
    end else if (reg_read_in) begin
      rdata_r <= rdata_nxt;
    end else begin
      rdata_r <= 32'h00000000;
    end
  end

  assign reg_rdata_out = rdata_r;
  assign gpio_event_out = event_any;
  assign irq_out = event_any & top_event_enable_r;
endmodule

//--- sgp_port_chk.sv
/* Checker for the six-pin port: reads, pin drive, event outputs.
   Assumes one clock and a synchronous reset. */
`timescale 1ns/10ps
module sgp_port_chk (
  input wire clock_in,
  input wire reset_in,
  input wire [11:0] reg_addr_in,
  input wire [31:0] reg_wdata_in,
  input wire reg_write_in,
  input wire reg_read_in,
  input wire [31:0] reg_rdata_out,
  input wire [5:0] pin_out,
  input wire [5:0] pin_oe_out,
  input wire [5:0] indicator_enable_in,
  input wire [5:0] indicator_value_in,
  input wire [5:0] indicator_oe_in,
  input wire gpio_event_out,
  input wire irq_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (reset_in);
  // Data write, then the driver register needs one more cycle
  sequence dd_wr;
    reg_write_in && reg_addr_in == 12'h1E4 && indicator_enable_in == 6'h00
      ##1 indicator_enable_in == 6'h00;
  endsequence
  irq_event_a: assert property (irq_out |-> gpio_event_out) else $error("irq without event");
  rdata_idle_a: assert property (!reg_read_in |=> reg_rdata_out == 32'h0) else $error("stray rdata");
  reserved_zero_a: assert property (reg_read_in && reg_addr_in[11:4] == 8'h1E |=>
    (reg_rdata_out & 32'hFFC0FFC0) == 32'h0) else $error("reserved bits set");
  drive_low_a: assert property (dd_wr |=> (pin_oe_out & ~pin_out) ==
    ($past(reg_wdata_in[21:16], 2) & ~$past(reg_wdata_in[5:0], 2))) else $error("low drive");
  input_release_a: assert property (dd_wr |=> (pin_oe_out & ~$past(reg_wdata_in[21:16], 2)) == 0
    && (pin_oe_out & pin_out & ~$past(reg_wdata_in[5:0], 2)) == 0) else $error("bad drive");
  pin_enable_a: assert property (reg_write_in && reg_addr_in == 12'h1E8 &&
    reg_wdata_in[21:16] == 6'h00 |=> !gpio_event_out) else $error("event while disabled");
  top_enable_a: assert property (reg_write_in && reg_addr_in == 12'h05C &&
    !reg_wdata_in[12] |=> !irq_out) else $error("irq while disabled");
  status_bit_a: assert property (reg_read_in && reg_addr_in == 12'h058 |=>
    reg_rdata_out == {19'h0, $past(gpio_event_out), 12'h0}) else $error("status read");
  indicator_a: assert property (indicator_enable_in == 6'h3F [*2] |->
    pin_out == $past(indicator_value_in) && pin_oe_out == $past(indicator_oe_in))
    else $error("indicator drive");
endmodule
bind sgp_port sgp_port_chk u_chk (.clock_in(clock_in), .reset_in(reset_in),
  .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_write_in(reg_write_in),
  .reg_read_in(reg_read_in), .reg_rdata_out(reg_rdata_out), .pin_out(pin_out),
  .pin_oe_out(pin_oe_out), .indicator_enable_in(indicator_enable_in),
  .indicator_value_in(indicator_value_in), .indicator_oe_in(indicator_oe_in),
  .gpio_event_out(gpio_event_out), .irq_out(irq_out));

//--- sgp_pins_model.sv
/* Board model of the six pins: port drivers, an outside source, pull-ups.
   Assumes the bench commands the outside source. */
`timescale 1ns/10ps
module sgp_pins_model (
  input wire [5:0] pin_out_in,
  input wire [5:0] pin_oe_in,
  input wire [5:0] ext_value_in,
  input wire [5:0] ext_enable_in,
  output wire [5:0] level_out
);
  // Released lines float high; source levels last many cycles, past 40 ns
  assign level_out = (pin_oe_in & pin_out_in) | (~pin_oe_in & ~ext_enable_in) |
    (~pin_oe_in & ext_enable_in & ext_value_in);
endmodule

//--- sgp_port_test.sv
/* Bench for the six-pin port: registers, pin drive, flags, events.
   Assumes the board model and the bound checker. */
`timescale 1ns/10ps
module sgp_port_test;
  reg clock_in = 1'b0;
  reg reset_in = 1'b1;
  reg [11:0] addr = 12'h000;
  reg [31:0] wdata = 32'h0;
  reg wr = 1'b0;
  reg rd = 1'b0;
  reg [5:0] ext_val = 6'h00;
  reg [5:0] ext_en = 6'h00;
  reg [5:0] ind_en = 6'h00;
  reg [5:0] ind_val = 6'h00;
  reg [5:0] ind_oe = 6'h00;
  wire [31:0] rdata;
  wire [5:0] pin_out, pin_oe, level;
  wire event_w, irq_w;
  integer fail_count = 0;
  integer compares = 0;
  integer i;
  reg [31:0] cfg, dd;
  always #5 clock_in = ~clock_in;
  sgp_port dut (.clock_in(clock_in), .reset_in(reset_in), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_write_in(wr), .reg_read_in(rd), .reg_rdata_out(rdata),
    .pin_in(level), .pin_out(pin_out), .pin_oe_out(pin_oe), .indicator_enable_in(ind_en),
    .indicator_value_in(ind_val), .indicator_oe_in(ind_oe), .gpio_event_out(event_w),
    .irq_out(irq_w));
  sgp_pins_model board (.pin_out_in(pin_out), .pin_oe_in(pin_oe), .ext_value_in(ext_val),
    .ext_enable_in(ext_en), .level_out(level));
  task check(input [31:0] got, input [31:0] exp);
    begin
      compares = compares + 1;
      if (got !== exp) begin
        fail_count = fail_count + 1;
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task idle(input integer n);
    repeat (n) @(posedge clock_in);
  endtask
  task wr_reg(input [11:0] a, input [31:0] d);
    begin
      @(posedge clock_in);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clock_in);
      wr <= 1'b0;
      #1;
    end
  endtask
  task rd_chk(input [11:0] a, input [31:0] exp);
    begin
      @(posedge clock_in);
      addr <= a;
      rd <= 1'b1;
      @(posedge clock_in);
      rd <= 1'b0;
      #1 check(rdata, exp);
    end
  endtask
  // Open-drain pins drive only their zeros
  function [5:0] exp_oe(input [31:0] c, input [31:0] d);
    exp_oe = d[21:16] & (c[5:0] | ~d[5:0]);
  endfunction
  function [5:0] exp_lvl(input [31:0] d);
    exp_lvl = (d[21:16] & d[5:0]) | (~d[21:16] & ext_val);
  endfunction
  task conclude;
    begin
      $display("compares=%0d fail_count=%0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
    end
  endtask
  initial begin
    void'($urandom(74216));
    idle(20);
    reset_in <= 1'b0;
    idle(6);
    rd_chk(12'h1E0, 32'h0);
    rd_chk(12'h1E4, 32'h3F);
    rd_chk(12'h1E8, 32'h0);
    wr_reg(12'h100, 32'hFFFFFFFF);
    rd_chk(12'h100, 32'h0);
    for (i = 0; i < 24; i = i + 1) begin
      cfg = (i == 0) ? 32'hFFC0FFC0 : $urandom;
      dd = (i == 0) ? 32'hFFFFFFD5 : $urandom;
      ext_en <= ~dd[21:16];
      ext_val <= $urandom;
      wr_reg(12'h1E0, cfg);
      wr_reg(12'h1E4, dd);
      idle(6);
      check(pin_oe, exp_oe(cfg, dd));
      check(level, exp_lvl(dd));
      rd_chk(12'h1E0, cfg & 32'h003F003F);
      rd_chk(12'h1E4, {10'h0, dd[21:16], 10'h0, exp_lvl(dd)});
    end
    wr_reg(12'h1E4, 32'h0);
    ext_en <= 6'h3F;
    ext_val <= 6'h00;
    wr_reg(12'h1E0, 32'h0);
    idle(6);
    wr_reg(12'h1E8, 32'h3F);
    rd_chk(12'h1E8, 32'h3F);
    check({event_w, irq_w}, 32'h0);
    wr_reg(12'h1E8, 32'h3F0000);
    check({event_w, irq_w}, 32'h2);
    wr_reg(12'h05C, 32'h1000);
    check(irq_w, 32'h1);
    rd_chk(12'h058, 32'h1000);
    ext_val <= 6'h3F;
    idle(6);
    wr_reg(12'h1E8, 32'h3F003F);
    rd_chk(12'h1E8, 32'h3F0000);
    check({event_w, irq_w}, 32'h0);
    wr_reg(12'h1E0, 32'h150000);
    idle(2);
    rd_chk(12'h1E8, 32'h3F0015);
    check(irq_w, 32'h1);
    ind_en <= 6'h3F;
    ind_val <= $urandom;
    ind_oe <= $urandom;
    idle(3);
    check({pin_oe, pin_out}, {ind_oe, ind_val});
    conclude;
  end
endmodule
